// [shared/rdc_pkg.sv]
package rdc_pkg;
    // widths of the message fields
    localparam int OFS_W = 32;
    localparam int LEN_W = 16;
    localparam int TAG_W = 16;
    // completion codes sent to the initiator frame router
    localparam logic [2:0] CMP_NONE = 3'h0;
    localparam logic [2:0] CMP_OFFSET_ERR = 3'h1;
    localparam logic [2:0] CMP_TOO_MUCH = 3'h2;
    localparam logic [2:0] CMP_BAD_LEN = 3'h3;
    localparam logic [2:0] CMP_CONN_FAIL = 3'h4;
    localparam logic [2:0] CMP_CANCEL_ACK = 3'h5;
    // interrupt status bit positions
    localparam int EV_ERR = 0;
    localparam int EV_CONN = 1;
    localparam int EV_CANCEL = 2;
    localparam int EV_DROP = 3;
    localparam int EV_W = 4;
    // register offsets; five address bits so the offset register has its own slot
    localparam logic [4:0] REG_CTRL = 5'h0;
    localparam logic [4:0] REG_STATUS = 5'h4;
    localparam logic [4:0] REG_CLEAR = 5'h8;
    localparam logic [4:0] REG_ENABLE = 5'hc;
    localparam logic [4:0] REG_OFFSET = 5'h10;
    // reset values
    localparam logic CTRL_RETRY_RST = 1'h0;
    typedef enum logic [1:0] {
        RDC_IDLE,
        RDC_SEND,
        RDC_RECV
    } rdc_state_type;
endpackage

// [hw/rdc_check.sv]
`timescale 1ns/1ps
// combinational verdict on one read data frame against the expected offset
module rdc_check #(
    parameter int OFS_W = rdc_pkg::OFS_W,
    parameter int LEN_W = rdc_pkg::LEN_W
) (
    input wire logic [OFS_W-1:0] frame_offset,
    input wire logic [LEN_W-1:0] frame_len,
    input wire logic [OFS_W-1:0] exp_offset,
    input wire logic [OFS_W-1:0] buf_size,
    input wire logic retry_en,
    input wire logic cdp,
    output logic [2:0] verdict,
    output logic start_drop
);
    // one extra bit so the sums cannot wrap past the buffer size
    wire [OFS_W:0] exp_end = {1'b0, exp_offset} + {{(OFS_W+1-LEN_W){1'b0}}, frame_len};
    wire [OFS_W:0] frm_end = {1'b0, frame_offset} + {{(OFS_W+1-LEN_W){1'b0}}, frame_len};
    wire mismatch = frame_offset != exp_offset;
    wire ofs_over = frame_offset > buf_size;
    wire ofs_err = (!retry_en && mismatch) || ofs_over;
    wire too_much = exp_end > {1'b0, buf_size};
    wire bad_len = frame_len == '0;
    // retry case: misplaced frame still inside the buffer starts a drop
    assign start_drop = retry_en && !cdp && mismatch && (frame_offset < buf_size)
        && (frm_end <= {1'b0, buf_size});
    // fixed priority, one completion only
    assign verdict = ofs_err ? rdc_pkg::CMP_OFFSET_ERR :
        too_much ? rdc_pkg::CMP_TOO_MUCH :
        bad_len ? rdc_pkg::CMP_BAD_LEN : rdc_pkg::CMP_NONE;
endmodule

// [hw/rdc_irq.sv]
`timescale 1ns/1ps
// sticky event bits, write-one clear, enable gating onto one level line
module rdc_irq #(
    parameter int W = rdc_pkg::EV_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] ev,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] en,
    output logic [W-1:0] status,
    output logic irq
);
    logic [W-1:0] status_r;
    logic irq_r;
    // a set in the clearing cycle wins, so no event is lost
    wire [W-1:0] status_nxt = (status_r & ~clr) | ev;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & en);
        end
    end
    assign status = status_r;
    assign irq = irq_r;
endmodule

// [hw/rdc_top.sv]
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - each read data arrival in receive state, except while dropping or alongside return-to-start, cancel or nak, is checked against offset and buffer size
// - retries off and offset not the expected one gives offset error
// - offset above buffer size gives offset error whatever the retry setting
// - expected offset plus byte count above buffer size gives too much data
// - zero data bytes gives incorrect data length
// - only one completion; offset error, then too much, then bad length
// - retries on, pointer bit clear, misplaced in-range offset starts dropping arrivals
// - dropping ends on the first arrival with the changing pointer bit set
// - good or resumed frame is delivered, expected offset becomes offset plus length
// - ack/nak timeout or connection lost sends connection-failed completion
// - after connection-failed the receive state is kept
// - cancel sends cancel-acknowledged completion carrying the command tag
// - the three failures, cancel ack, or return-to-start go back to idle
// - nak for the read command frame goes back to frame send state
// - receive state entered on transmission of a read command frame, no ack wait
module rdc_top #(
    parameter int OFS_W = rdc_pkg::OFS_W,
    parameter int LEN_W = rdc_pkg::LEN_W,
    parameter int TAG_W = rdc_pkg::TAG_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    // command side
    input wire logic cmd_start,
    input wire logic [TAG_W-1:0] cmd_tag,
    input wire logic [OFS_W-1:0] cmd_buf_size,
    input wire logic cmd_sent,
    input wire logic cmd_nak,
    // messages from the port layer and frame router
    input wire logic data_in_valid,
    input wire logic [OFS_W-1:0] data_in_offset,
    input wire logic [LEN_W-1:0] data_in_len,
    input wire logic data_in_cdp,
    input wire logic ack_nak_timeout,
    input wire logic conn_lost,
    input wire logic cancel_req,
    input wire logic return_to_start,
    // to the initiator frame router
    output logic cmp_valid,
    output logic [2:0] cmp_code,
    output logic [TAG_W-1:0] cmp_tag,
    output logic deliver_valid,
    output logic [OFS_W-1:0] deliver_offset,
    output logic [LEN_W-1:0] deliver_len,
    output logic resend_cmd,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    // the offset must fit the 32-bit read port and hold any frame length
    if (OFS_W > 32 || OFS_W < LEN_W || TAG_W > 32) begin : g_width_check
        $error("rdc_top: unsupported widths");
    end

    rdc_pkg::rdc_state_type state_r, state_nxt;
    logic [OFS_W-1:0] exp_ofs_r;
    logic [OFS_W-1:0] buf_size_r;
    logic [TAG_W-1:0] tag_r;
    logic drop_r;
    logic retry_r;
    logic [rdc_pkg::EV_W-1:0] irq_en_r;
    logic cmp_valid_r;
    logic [2:0] cmp_code_r;
    logic [TAG_W-1:0] cmp_tag_r;
    logic deliver_valid_r;
    logic [OFS_W-1:0] deliver_offset_r;
    logic [LEN_W-1:0] deliver_len_r;
    logic resend_r;
    logic [31:0] rdata_r;

    wire [2:0] verdict;
    wire start_drop;
    wire [rdc_pkg::EV_W-1:0] ev_status;

    rdc_check #(
        .OFS_W(OFS_W),
        .LEN_W(LEN_W)
    ) u_check (
        .frame_offset(data_in_offset),
        .frame_len(data_in_len),
        .exp_offset(exp_ofs_r),
        .buf_size(buf_size_r),
        .retry_en(retry_r),
        .cdp(data_in_cdp),
        .verdict(verdict),
        .start_drop(start_drop)
    );

    // message decode, only meaningful in the receive state
    wire in_recv = state_r == rdc_pkg::RDC_RECV;
    wire rts = in_recv && return_to_start;
    wire cancel = in_recv && !rts && cancel_req;
    wire nak = in_recv && !rts && !cancel && cmd_nak;
    wire arrive = in_recv && !rts && !cancel && !nak && data_in_valid;
    // a frame with the pointer bit set ends the drop and is then processed
    wire dropped = arrive && drop_r && !data_in_cdp;
    wire checked = arrive && !dropped;
    // while dropping, the resuming frame is taken as the new position
    wire resumed = checked && drop_r;
    wire go_drop = checked && !resumed && start_drop;
    wire fail = checked && !resumed && !start_drop && verdict != rdc_pkg::CMP_NONE;
    wire good = checked && (resumed || (!start_drop && verdict == rdc_pkg::CMP_NONE));
    wire conn_fail = in_recv && !rts && (ack_nak_timeout || conn_lost);
    wire [OFS_W:0] next_ofs_w = {1'b0, data_in_offset} +
        {{(OFS_W+1-LEN_W){1'b0}}, data_in_len};

    // state sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rdc_pkg::RDC_IDLE: begin
                if (cmd_start) begin
                    state_nxt = rdc_pkg::RDC_SEND;
                end
            end
            rdc_pkg::RDC_SEND: begin
                if (cmd_sent) begin
                    state_nxt = rdc_pkg::RDC_RECV;
                end
            end
            rdc_pkg::RDC_RECV: begin
                if (rts || cancel || fail) begin
                    state_nxt = rdc_pkg::RDC_IDLE;
                end else if (nak) begin
                    state_nxt = rdc_pkg::RDC_SEND;
                end else begin
                    state_nxt = rdc_pkg::RDC_RECV;
                end
            end
            default: begin
                state_nxt = rdc_pkg::RDC_IDLE;
            end
        endcase
    end

    // state, command context and drop flag
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= rdc_pkg::RDC_IDLE;
            buf_size_r <= '0;
            tag_r <= '0;
            drop_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == rdc_pkg::RDC_IDLE && cmd_start) begin
                buf_size_r <= cmd_buf_size;
                tag_r <= cmd_tag;
            end
            if (state_nxt != rdc_pkg::RDC_RECV || resumed) begin
                drop_r <= 1'b0;
            end else if (go_drop) begin
                drop_r <= 1'b1;
            end
        end
    end

    // expected read offset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            exp_ofs_r <= '0;
        end else if (state_r == rdc_pkg::RDC_IDLE && cmd_start) begin
            exp_ofs_r <= '0;
        end else if (good) begin
            exp_ofs_r <= next_ofs_w[OFS_W-1:0];
        end
    end

    // completion, with connection failure below the frame verdicts
    wire cmp_fire = cancel || fail || conn_fail;
    wire [2:0] cmp_sel = cancel ? rdc_pkg::CMP_CANCEL_ACK :
        fail ? verdict : rdc_pkg::CMP_CONN_FAIL;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_valid_r <= 1'b0;
            cmp_code_r <= rdc_pkg::CMP_NONE;
            cmp_tag_r <= '0;
        end else begin
            cmp_valid_r <= cmp_fire;
            if (cmp_fire) begin
                cmp_code_r <= cmp_sel;
                cmp_tag_r <= tag_r;
            end
        end
    end

    // data delivery and resend request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            deliver_valid_r <= 1'b0;
            deliver_offset_r <= '0;
            deliver_len_r <= '0;
            resend_r <= 1'b0;
        end else begin
            deliver_valid_r <= good;
            if (good) begin
                deliver_offset_r <= data_in_offset;
                deliver_len_r <= data_in_len;
            end
            resend_r <= nak;
        end
    end

    // events for the interrupt block
    wire [rdc_pkg::EV_W-1:0] events = {go_drop, cancel, conn_fail, fail};
    wire clr_wr = reg_wr && reg_addr == rdc_pkg::REG_CLEAR;
    wire [rdc_pkg::EV_W-1:0] clr_bits = clr_wr ? reg_wdata[rdc_pkg::EV_W-1:0] : '0;

    rdc_irq #(
        .W(rdc_pkg::EV_W)
    ) u_irq (
        .core_clk(core_clk),
        .rstn(rstn),
        .ev(events),
        .clr(clr_bits),
        .en(irq_en_r),
        .status(ev_status),
        .irq(irq)
    );

    // control registers written by software
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            retry_r <= rdc_pkg::CTRL_RETRY_RST;
            irq_en_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr == rdc_pkg::REG_CTRL) begin
                retry_r <= reg_wdata[0];
            end
            if (reg_addr == rdc_pkg::REG_ENABLE) begin
                irq_en_r <= reg_wdata[rdc_pkg::EV_W-1:0];
            end
        end
    end

    // read mux; unmapped and write-only offsets read as zero
    wire [31:0] rd_mux = (reg_addr == rdc_pkg::REG_CTRL) ? {31'h0, retry_r} :
        (reg_addr == rdc_pkg::REG_STATUS) ? {{(32-rdc_pkg::EV_W){1'b0}}, ev_status} :
        (reg_addr == rdc_pkg::REG_ENABLE) ? {{(32-rdc_pkg::EV_W){1'b0}}, irq_en_r} :
        (reg_addr == rdc_pkg::REG_OFFSET) ? 32'(exp_ofs_r) : 32'h0;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign cmp_valid = cmp_valid_r;
    assign cmp_code = cmp_code_r;
    assign cmp_tag = cmp_tag_r;
    assign deliver_valid = deliver_valid_r;
    assign deliver_offset = deliver_offset_r;
    assign deliver_len = deliver_len_r;
    assign resend_cmd = resend_r;
    assign reg_rdata = rdata_r;
endmodule

// [tb/rdc_chk.sv]
`timescale 1ns/1ps
// port-level watch on the read data checker
module rdc_chk #(
    parameter int OFS_W = rdc_pkg::OFS_W,
    parameter int LEN_W = rdc_pkg::LEN_W,
    parameter int TAG_W = rdc_pkg::TAG_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cmd_start,
    input wire logic [TAG_W-1:0] cmd_tag,
    input wire logic [OFS_W-1:0] cmd_buf_size,
    input wire logic cmd_nak,
    input wire logic data_in_valid,
    input wire logic [OFS_W-1:0] data_in_offset,
    input wire logic [LEN_W-1:0] data_in_len,
    input wire logic ack_nak_timeout,
    input wire logic conn_lost,
    input wire logic cancel_req,
    input wire logic cmp_valid,
    input wire logic [2:0] cmp_code,
    input wire logic [TAG_W-1:0] cmp_tag,
    input wire logic deliver_valid,
    input wire logic [OFS_W-1:0] deliver_offset,
    input wire logic [LEN_W-1:0] deliver_len,
    input wire logic resend_cmd
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [TAG_W-1:0] tag_r;
    logic [OFS_W-1:0] buf_r;
    logic fail;
    // copy of the command arguments, taken on every cmd_start pulse, in any state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tag_r <= '0;
            buf_r <= '0;
        end else if (cmd_start) begin
            tag_r <= cmd_tag;
            buf_r <= cmd_buf_size;
        end
    end
    // the three frame verification failures
    assign fail = cmp_valid && cmp_code >= rdc_pkg::CMP_OFFSET_ERR
        && cmp_code <= rdc_pkg::CMP_BAD_LEN;
    a_fail_cause: assert property (fail |-> $past(data_in_valid))
        else $error("failure completion without a frame");
    a_deliver_echo: assert property (deliver_valid |-> $past(data_in_valid)
        && deliver_offset == $past(data_in_offset) && deliver_len == $past(data_in_len))
        else $error("delivered frame differs from arrival");
    a_len_nonzero: assert property (deliver_valid |-> deliver_len != '0)
        else $error("empty frame delivered");
    a_fits_buffer: assert property (deliver_valid |-> deliver_offset + deliver_len <= buf_r)
        else $error("delivered frame runs past the buffer");
    a_one_result: assert property (!(fail && deliver_valid))
        else $error("frame failure and delivery together");
    a_conn_cause: assert property (cmp_valid && cmp_code == rdc_pkg::CMP_CONN_FAIL
        |-> $past(ack_nak_timeout || conn_lost))
        else $error("connection failure without cause");
    a_cancel_tag: assert property (cmp_valid && cmp_code == rdc_pkg::CMP_CANCEL_ACK
        |-> $past(cancel_req) && cmp_tag == tag_r)
        else $error("cancel ack wrong cause or tag");
    a_fail_ends: assert property (fail |=> !deliver_valid [*2])
        else $error("delivery after a failure completion");
    a_resend_cause: assert property (resend_cmd |-> $past(cmd_nak))
        else $error("resend without nak");
endmodule
bind rdc_top rdc_chk #(.OFS_W(OFS_W), .LEN_W(LEN_W), .TAG_W(TAG_W)) chk (
    .core_clk(core_clk), .rstn(rstn), .cmd_start(cmd_start), .cmd_tag(cmd_tag),
    .cmd_buf_size(cmd_buf_size), .cmd_nak(cmd_nak), .data_in_valid(data_in_valid),
    .data_in_offset(data_in_offset), .data_in_len(data_in_len),
    .ack_nak_timeout(ack_nak_timeout), .conn_lost(conn_lost), .cancel_req(cancel_req),
    .cmp_valid(cmp_valid), .cmp_code(cmp_code), .cmp_tag(cmp_tag),
    .deliver_valid(deliver_valid), .deliver_offset(deliver_offset),
    .deliver_len(deliver_len), .resend_cmd(resend_cmd));

// [tb/rdc_tgt.sv]
`timescale 1ns/1ps
// far end: target port handing read data frames in through the port layer
module rdc_tgt (
    input wire logic core_clk,
    output logic data_in_valid,
    output logic [rdc_pkg::OFS_W-1:0] data_in_offset,
    output logic [rdc_pkg::LEN_W-1:0] data_in_len,
    output logic data_in_cdp
);
    initial begin
        data_in_valid = 1'h0;
        data_in_offset = 32'h0;
        data_in_len = 16'h0;
        data_in_cdp = 1'h0;
    end
    // one frame a call; fields are inverted after so stale values never pass as valid
    task automatic frame(input logic [31:0] ofs, input logic [15:0] len, input logic cdp);
        @(posedge core_clk);
        data_in_valid <= 1'h1;
        data_in_offset <= ofs;
        data_in_len <= len;
        data_in_cdp <= cdp;
        @(posedge core_clk);
        data_in_valid <= 1'h0;
        data_in_offset <= ~ofs;
        data_in_len <= ~len;
        data_in_cdp <= ~cdp;
    endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`define CK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic [6:0] ev = 7'h0;
    logic [4:0] reg_addr = 5'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic dv, cdp, cv, delv, rsnd, irq;
    logic [31:0] dofs, rdata, dlo;
    logic [15:0] dlen, ctag, dll;
    logic [2:0] code;
    int bad_count = 0;
    int cmp_count = 0;
    always #2 core_clk = ~core_clk;
    rdc_tgt far (.core_clk(core_clk), .data_in_valid(dv), .data_in_offset(dofs),
        .data_in_len(dlen), .data_in_cdp(cdp));
    // ev bits: start, sent, nak, timeout, lost, cancel, return to start
    rdc_top uut (.core_clk(core_clk), .rstn(rstn), .cmd_start(ev[0]), .cmd_tag(16'h5a3c),
        .cmd_buf_size(32'h20), .cmd_sent(ev[1]), .cmd_nak(ev[2]), .data_in_valid(dv),
        .data_in_offset(dofs), .data_in_len(dlen), .data_in_cdp(cdp),
        .ack_nak_timeout(ev[3]), .conn_lost(ev[4]), .cancel_req(ev[5]),
        .return_to_start(ev[6]), .cmp_valid(cv), .cmp_code(code), .cmp_tag(ctag),
        .deliver_valid(delv), .deliver_offset(dlo), .deliver_len(dll), .resend_cmd(rsnd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .irq(irq));
    task automatic pulse(input logic [6:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 7'h0;
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // completion code (zero when none) and delivery seen one cycle after the cause
    task automatic res(input logic [2:0] c, input logic d);
        `CK("result", {c, d}, {cv ? code : 3'h0, delv})
    endtask
    task automatic fr(input logic [31:0] o, input logic [15:0] l, input logic p,
        input logic [2:0] c, input logic d);
        far.frame(o, l, p);
        #1;
        res(c, d);
        if (d) begin
            `CK("deliver_offset", o, dlo)
            `CK("deliver_len", l, dll)
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        `CK("reg_rdata", e, rdata)
    endtask
    task automatic open_rd();
        pulse(7'h01);
        pulse(7'h02);
    endtask
    task automatic t_good();
        rd(rdc_pkg::REG_CTRL, 32'h0);
        rd(rdc_pkg::REG_ENABLE, 32'h0);
        rd(5'h2, 32'h0);
        open_rd();
        fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h1);
        rd(rdc_pkg::REG_OFFSET, 32'h8);
        fr(32'h8, 16'h18, 1'h0, rdc_pkg::CMP_NONE, 1'h1);
        pulse(7'h40);
        fr(32'h20, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        open_rd();
        rd(rdc_pkg::REG_OFFSET, 32'h0);
        pulse(7'h40);
        $display("test good done");
    endtask
    task automatic t_err();
        logic [31:0] o[4] = '{32'h4, 32'h28, 32'h0, 32'h0};
        logic [15:0] l[4] = '{16'h8, 16'h0, 16'h28, 16'h0};
        logic [2:0] c[4] = '{rdc_pkg::CMP_OFFSET_ERR, rdc_pkg::CMP_OFFSET_ERR,
            rdc_pkg::CMP_TOO_MUCH, rdc_pkg::CMP_BAD_LEN};
        for (int i = 0; i < 4; i++) begin
            open_rd();
            fr(o[i], l[i], 1'h0, c[i], 1'h0);
            fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        end
        $display("test err done");
    endtask
    task automatic t_retry();
        wr(rdc_pkg::REG_CTRL, 32'h1);
        open_rd();
        fr(32'h8, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        fr(32'h10, 16'h4, 1'h1, rdc_pkg::CMP_NONE, 1'h1);
        rd(rdc_pkg::REG_OFFSET, 32'h14);
        fr(32'h28, 16'h4, 1'h0, rdc_pkg::CMP_OFFSET_ERR, 1'h0);
        wr(rdc_pkg::REG_CTRL, 32'h0);
        $display("test retry done");
    endtask
    task automatic t_conn();
        open_rd();
        pulse(7'h08);
        res(rdc_pkg::CMP_CONN_FAIL, 1'h0);
        pulse(7'h10);
        res(rdc_pkg::CMP_CONN_FAIL, 1'h0);
        fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h1);
        pulse(7'h20);
        res(rdc_pkg::CMP_CANCEL_ACK, 1'h0);
        `CK("cmp_tag", 16'h5a3c, ctag)
        fr(32'h8, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        open_rd();
        pulse(7'h04);
        `CK("resend_cmd", 1'h1, rsnd)
        fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h0);
        pulse(7'h02);
        fr(32'h0, 16'h8, 1'h0, rdc_pkg::CMP_NONE, 1'h1);
        pulse(7'h40);
        $display("test conn done");
    endtask
    task automatic t_irq();
        wr(rdc_pkg::REG_CLEAR, 32'hf);
        wr(rdc_pkg::REG_ENABLE, 32'h1);
        open_rd();
        fr(32'h0, 16'h0, 1'h0, rdc_pkg::CMP_BAD_LEN, 1'h0);
        tick(3);
        `CK("irq", 1'h1, irq)
        rd(rdc_pkg::REG_STATUS, 32'h1);
        wr(rdc_pkg::REG_ENABLE, 32'h0);
        tick(3);
        `CK("irq", 1'h0, irq)
        wr(rdc_pkg::REG_ENABLE, 32'h1);
        wr(rdc_pkg::REG_CLEAR, 32'h1);
        tick(3);
        `CK("irq", 1'h0, irq)
        rd(rdc_pkg::REG_STATUS, 32'h0);
        $display("test irq done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog well past the roughly 140 cycles the tests need
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        t_good();
        t_err();
        t_retry();
        t_conn();
        t_irq();
        finish_test();
    end
endmodule
